// file: rtl/cspc_core.sv
`timescale 1ns/1ps
// What this block does
// - Flag-affecting op aimed at status: data write skips zero, nibble and carry; they follow flag logic only.
// - Software writes never change the watchdog-expiry and sleep-entered flags.
// - Expiry flag set by reset, refresh or halt; cleared by watchdog time-out.
// - Sleep flag set by reset or refresh; cleared by low-power halt.
// - Zero flag is one exactly when the affecting result is zero.
// - Nibble flag: add carry out of low nibble; subtract no-borrow there.
// - Carry: add carry, subtract no-borrow, rotates load the bit shifted out.
// - Two page bits pick one of four 512-word program pages.
// - Spare status bit 7 resets to zero.
// - Six-bit write-only timer config loads accumulator only on its load op.
// - Any reset sets all six timer config bits.
// - Config bit 5 picks external pin transitions or instruction cycles.
// - Config bit 4 picks falling edges when one, rising when zero.
// - Config bit 3 gives the prescaler to watchdog when one, timer when zero.
// - Prescale n divides timer by 2^(n+1), watchdog by 2^n.
// - Program counter advances by one each cycle unless loaded.
// - Jump loads counter bits 8:0 from the nine-bit target.
// - Jump, call, computed jump copy page bits into counter bits 10:9.
// - Call or low-byte write loads bits 7:0 and clears bit 8.
// - Only counter bits 7:0 are visible through the low-byte register.
// - Files reached directly or through the pointer; address zero is the window.
// - Lower sixteen addresses of every bank alias to bank 0.
// - Reset sets counter to all ones and clears page bits.
module cspc_core #(
	parameter int PC_W = 11,
	parameter int BANK_W = 3
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic op_valid,
	input wire cspc_pkg::cspc_op_t op_kind,
	input wire logic [4:0] op_addr,
	input wire logic op_dest_file,
	input wire logic [7:0] acc_in,
	input wire logic jump_op,
	input wire logic [8:0] jump_target,
	input wire logic call_op,
	input wire logic [7:0] call_target,
	input wire logic config_load_op,
	input wire logic direction_load_op,
	input wire logic watchdog_refresh_op,
	input wire logic halt_op,
	input wire logic watchdog_timeout,
	input wire logic watchdog_base_tick,
	input wire logic timer_ext_input,
	output logic [7:0] status_flags,
	output logic [PC_W-1:0] program_counter,
	output logic [7:0] acc_result,
	output logic acc_result_valid,
	output logic [5:0] timer_config,
	output logic [7:0] pin_direction,
	output logic timer_tick,
	output logic watchdog_tick
);
	// ---------------------------------------------------------------
	// Elaboration checks
	// ---------------------------------------------------------------
	if (PC_W != 9 && PC_W != 11) begin : g_bad_pc
		$error("PC_W must be 9 or 11");
	end
	if (BANK_W < 0 || BANK_W > 3) begin : g_bad_bank
		$error("BANK_W must be 0 to 3");
	end

	localparam int MEM_WORDS = cspc_pkg::SHARED_REGS * (1 + (1 << BANK_W));

	logic [7:0] indirect_pointer;
	logic [7:0] mem [0:MEM_WORDS-1];
	logic [7:0] psc_cnt;
	logic ext_s1;
	logic ext_s2;
	logic ext_s3;

	// ---------------------------------------------------------------
	// Address resolution
	// ---------------------------------------------------------------
	wire is_indirect = op_addr == cspc_pkg::ADDR_INDIRECT;
	wire [4:0] eff_addr = is_indirect ? indirect_pointer[4:0] : op_addr;
	wire [2:0] bank = 3'(indirect_pointer[7:5] & 3'((1 << BANK_W) - 1));
	wire [7:0] mem_idx = eff_addr[4] ? ({1'b0, bank, eff_addr[3:0]} + 8'h10) : {4'h0, eff_addr[3:0]};
	wire hit_null = eff_addr == cspc_pkg::ADDR_INDIRECT;
	wire hit_pcl = eff_addr == cspc_pkg::ADDR_PC_LOW;
	wire hit_status = eff_addr == cspc_pkg::ADDR_STATUS;
	wire hit_ptr = eff_addr == cspc_pkg::ADDR_POINTER;
	wire hit_mem = !(hit_null || hit_pcl || hit_status || hit_ptr);
	wire [7:0] operand = hit_null ? 8'h00 : hit_pcl ? program_counter[7:0] :
		hit_status ? status_flags : hit_ptr ? indirect_pointer : mem[mem_idx];

	// ---------------------------------------------------------------
	// Arithmetic and flags
	// ---------------------------------------------------------------
	wire is_add = op_kind == cspc_pkg::OP_ADD;
	wire is_sub = op_kind == cspc_pkg::OP_SUB;
	wire is_rr = op_kind == cspc_pkg::OP_ROT_R;
	wire is_rl = op_kind == cspc_pkg::OP_ROT_L;
	wire [8:0] add_sum = {1'b0, operand} + {1'b0, acc_in};
	wire [4:0] add_nib = {1'b0, operand[3:0]} + {1'b0, acc_in[3:0]};
	wire [8:0] sub_dif = {1'b0, operand} - {1'b0, acc_in};
	wire [4:0] sub_nib = {1'b0, operand[3:0]} - {1'b0, acc_in[3:0]};
	wire [7:0] result = is_add ? add_sum[7:0] : is_sub ? sub_dif[7:0] :
		is_rr ? {status_flags[cspc_pkg::ST_CARRY], operand[7:1]} :
		is_rl ? {operand[6:0], status_flags[cspc_pkg::ST_CARRY]} : acc_in;
	wire upd_z = op_valid && (is_add || is_sub || op_kind == cspc_pkg::OP_PASS_Z);
	wire upd_dc = op_valid && (is_add || is_sub);
	wire upd_c = op_valid && (is_add || is_sub || is_rr || is_rl);
	wire flag_z = result == 8'h00;
	wire flag_dc = is_add ? add_nib[4] : !sub_nib[4];
	wire flag_c = is_add ? add_sum[8] : is_sub ? !sub_dif[8] : is_rr ? operand[0] : operand[7];
	wire file_wr = op_valid && op_dest_file;
	wire status_wr = file_wr && hit_status;
	wire pcl_wr = file_wr && hit_pcl;

	// ---------------------------------------------------------------
	// Status next value
	// ---------------------------------------------------------------
	wire any_flag = upd_z || upd_c;
	wire [7:0] st_data = status_wr ? result : status_flags;
	wire next_c = upd_c ? flag_c : (any_flag ? status_flags[0] : st_data[0]);
	wire next_dc = upd_dc ? flag_dc : (any_flag ? status_flags[1] : st_data[1]);
	wire next_z = upd_z ? flag_z : (any_flag ? status_flags[2] : st_data[2]);
	wire next_sleep_n = halt_op ? 1'b0 : watchdog_refresh_op ? 1'b1 : status_flags[3];
	wire next_expiry_n = watchdog_timeout ? 1'b0 :
		(watchdog_refresh_op || halt_op) ? 1'b1 : status_flags[4];
	wire [7:0] next_status = {st_data[7:5], next_expiry_n, next_sleep_n, next_z, next_dc, next_c};

	// ---------------------------------------------------------------
	// Program counter next value
	// ---------------------------------------------------------------
	wire [1:0] page = status_flags[cspc_pkg::ST_PAGE_HI:cspc_pkg::ST_PAGE_LO];
	wire [10:0] jump_full = {page, jump_target};
	wire [10:0] call_full = {page, 1'b0, call_target};
	wire [10:0] pcl_full = {page, 1'b0, result};
	wire [PC_W-1:0] next_pc = jump_op ? jump_full[PC_W-1:0] : call_op ? call_full[PC_W-1:0] :
		pcl_wr ? pcl_full[PC_W-1:0] : PC_W'(program_counter + 1'b1);

	// ---------------------------------------------------------------
	// Register updates
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			status_flags <= cspc_pkg::STATUS_RST;
			program_counter <= '1;
			indirect_pointer <= cspc_pkg::POINTER_RST;
		end else if (clk_en) begin
			status_flags <= next_status;
			program_counter <= next_pc;
			if (file_wr && hit_ptr) begin
				indirect_pointer <= result;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (clk_en && file_wr && hit_mem) begin
			mem[mem_idx] <= result;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acc_result <= 8'h00;
			acc_result_valid <= 1'b0;
		end else if (clk_en) begin
			acc_result_valid <= op_valid && !op_dest_file;
			if (op_valid && !op_dest_file) begin
				acc_result <= result;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			timer_config <= cspc_pkg::CONFIG_RST;
			pin_direction <= cspc_pkg::DIRECTION_RST;
		end else if (clk_en) begin
			if (config_load_op) begin
				timer_config <= acc_in[5:0];
			end
			if (direction_load_op) begin
				pin_direction <= acc_in;
			end
		end
	end

	// ---------------------------------------------------------------
	// Timer source and shared prescaler
	// ---------------------------------------------------------------
	wire src_ext = timer_config[cspc_pkg::CFG_SOURCE];
	wire edge_fall = timer_config[cspc_pkg::CFG_EDGE];
	wire psc_wdog = timer_config[cspc_pkg::CFG_TARGET];
	wire ext_edge = edge_fall ? (ext_s3 && !ext_s2) : (!ext_s3 && ext_s2);
	wire timer_evt = src_ext ? ext_edge : 1'b1;
	wire psc_evt = psc_wdog ? watchdog_base_tick : timer_evt;
	wire [3:0] shift = psc_wdog ? {1'b0, timer_config[2:0]} : 4'({1'b0, timer_config[2:0]} + 4'h1);
	wire [8:0] mask = 9'((9'h001 << shift) - 9'h001);
	wire psc_full = (psc_cnt & mask[7:0]) == mask[7:0];
	wire next_timer_tick = timer_evt && (psc_wdog || psc_full);
	wire next_wdog_tick = watchdog_base_tick && (!psc_wdog || psc_full);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
		end else if (clk_en) begin
			ext_s1 <= timer_ext_input;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end

	// The prescaler restarts whenever the configuration is reloaded.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			psc_cnt <= 8'h00;
			timer_tick <= 1'b0;
			watchdog_tick <= 1'b0;
		end else if (clk_en) begin
			timer_tick <= next_timer_tick;
			watchdog_tick <= next_wdog_tick;
			if (config_load_op) begin
				psc_cnt <= 8'h00;
			end else if (psc_evt) begin
				psc_cnt <= psc_full ? 8'h00 : 8'(psc_cnt + 8'h01);
			end
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	flag_write_block_a: assert property (
		clk_en && op_valid && op_dest_file && hit_status && is_add
		|=> status_flags[2:0] == $past({add_sum[7:0] == 8'h00, add_nib[4], add_sum[8]}))
		else $error("status data write reached flag bits");
	sticky_no_write_a: assert property (
		clk_en && status_wr && !watchdog_timeout && !watchdog_refresh_op && !halt_op
		|=> status_flags[4:3] == $past(status_flags[4:3]))
		else $error("software changed expiry or sleep flag");
	timeout_clear_a: assert property (
		clk_en && watchdog_timeout |=> !status_flags[cspc_pkg::ST_EXPIRY_N])
		else $error("expiry flag not cleared by time-out");
	halt_flags_a: assert property (
		clk_en && halt_op && !watchdog_timeout |=> status_flags[4:3] == 2'b10)
		else $error("halt did not set expiry and clear sleep flag");
	zero_flag_a: assert property (
		clk_en && upd_z |=> status_flags[cspc_pkg::ST_ZERO] == ($past(result) == 8'h00))
		else $error("zero flag wrong");
	sub_carry_a: assert property (
		clk_en && op_valid && is_sub |=> status_flags[cspc_pkg::ST_CARRY] == ($past(operand) >= $past(acc_in)))
		else $error("subtract carry wrong");
	pc_advance_a: assert property (
		clk_en && !jump_op && !call_op && !pcl_wr |=> program_counter == PC_W'($past(program_counter) + 1'b1))
		else $error("counter did not advance by one");
	jump_load_a: assert property (
		clk_en && jump_op |=> program_counter[8:0] == $past(jump_target))
		else $error("jump target not loaded");
	call_bit8_a: assert property (
		clk_en && !jump_op && (call_op || pcl_wr) |=> !program_counter[8])
		else $error("bit 8 not cleared on call or low-byte write");
	config_load_a: assert property (
		clk_en && config_load_op |=> timer_config == $past(acc_in[5:0]))
		else $error("timer config not loaded");
	wdog_div1_a: assert property (
		clk_en && psc_wdog && timer_config[2:0] == 3'h0 && watchdog_base_tick |=> watchdog_tick)
		else $error("watchdog 1:1 tick missing");

	// The checks below restate the flag and counter rules from operand and the inputs, without reusing the computed flag wires.
	rotate_carry_a: assert property (
		clk_en && op_valid && (is_rr || is_rl) |=> status_flags[0] == $past(is_rr ? operand[0] : operand[7]))
		else $error("rotate carry wrong");
	add_nibble_a: assert property (
		clk_en && op_valid && is_add
		|=> status_flags[1] == (({1'b0, $past(operand[3:0])} + {1'b0, $past(acc_in[3:0])}) > 5'h0f))
		else $error("add nibble carry wrong");
	call_load_a: assert property (
		clk_en && !jump_op && call_op |=> program_counter[7:0] == $past(call_target))
		else $error("call target not loaded");
	refresh_flags_a: assert property (
		clk_en && watchdog_refresh_op && !watchdog_timeout && !halt_op |=> status_flags[4:3] == 2'b11)
		else $error("refresh did not set expiry and sleep flags");
	window_read_a: assert property (
		clk_en && op_valid && hit_null && !op_dest_file && op_kind == cspc_pkg::OP_PASS_Z
		|=> acc_result == $past(acc_in))
		else $error("window op result wrong");
	freeze_hold_a: assert property (
		!clk_en |=> $stable(program_counter) && $stable(status_flags) && $stable(timer_config))
		else $error("state moved while clock enable low");

	jump_seen_c: cover property (clk_en && jump_op);
	status_add_c: cover property (clk_en && status_wr && is_add);
	halt_seen_c: cover property (clk_en && halt_op);
	timer_tick_c: cover property (timer_tick && src_ext);
endmodule

// file: rtl/cspc_pkg.sv
package cspc_pkg;
	// ---------------------------------------------------------------
	// Register file addresses
	// ---------------------------------------------------------------
	localparam logic [4:0] ADDR_INDIRECT = 5'h00;
	localparam logic [4:0] ADDR_PC_LOW = 5'h02;
	localparam logic [4:0] ADDR_STATUS = 5'h03;
	localparam logic [4:0] ADDR_POINTER = 5'h04;
	localparam int SHARED_REGS = 16;
	// ---------------------------------------------------------------
	// Status and configuration fields
	// ---------------------------------------------------------------
	localparam int ST_CARRY = 0;
	localparam int ST_NIBBLE = 1;
	localparam int ST_ZERO = 2;
	localparam int ST_SLEEP_N = 3;
	localparam int ST_EXPIRY_N = 4;
	localparam int ST_PAGE_LO = 5;
	localparam int ST_PAGE_HI = 6;
	localparam int ST_SPARE = 7;
	localparam int CFG_SOURCE = 5;
	localparam int CFG_EDGE = 4;
	localparam int CFG_TARGET = 3;
	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] STATUS_RST = 8'h18;
	localparam logic [5:0] CONFIG_RST = 6'h3f;
	localparam logic [7:0] DIRECTION_RST = 8'hff;
	localparam logic [7:0] POINTER_RST = 8'h00;
	// ---------------------------------------------------------------
	// Operation kinds
	// ---------------------------------------------------------------
	typedef enum logic [5:0] {
		OP_PASS = 6'b000001,
		OP_PASS_Z = 6'b000010,
		OP_ADD = 6'b000100,
		OP_SUB = 6'b001000,
		OP_ROT_R = 6'b010000,
		OP_ROT_L = 6'b100000
	} cspc_op_t;
endpackage

// file: verification/core_sfr_and_pc_logic_tb.sv
`timescale 1ns/1ps
module core_sfr_and_pc_logic_tb;
	// ---------------------------------------------------------------
	// Stimulus and observation
	// ---------------------------------------------------------------
	localparam logic [7:0] S_OP = 8'h80, S_JMP = 8'h40, S_CALL = 8'h20, S_CFG = 8'h10;
	localparam logic [7:0] S_DIR = 8'h08, S_REF = 8'h04, S_HALT = 8'h02, S_TO = 8'h01;
	logic clk = 1'h0, rstn = 1'h0, clk_en = 1'h1, op_valid = 1'h0, jump_op = 1'h0, call_op = 1'h0;
	logic config_load_op = 1'h0, direction_load_op = 1'h0, watchdog_refresh_op = 1'h0, halt_op = 1'h0;
	logic watchdog_timeout = 1'h0, watchdog_base_tick = 1'h0, timer_ext_input = 1'h0, op_dest_file = 1'h0;
	cspc_pkg::cspc_op_t op_kind = cspc_pkg::OP_PASS;
	logic [4:0] op_addr = 5'h00;
	logic [7:0] acc_in = 8'h00, call_target = 8'h00;
	logic [8:0] jump_target = 9'h000;
	logic [7:0] status_flags, acc_result, pin_direction;
	logic [10:0] program_counter;
	logic [5:0] timer_config;
	logic acc_result_valid, timer_tick, watchdog_tick;
	int n_mismatch = 0, comparisons = 0, tt = 0, wt = 0;
	always #2.5 clk = ~clk;
	cspc_core #(.PC_W(11), .BANK_W(3)) uut (.clk, .rstn, .clk_en, .op_valid, .op_kind, .op_addr, .op_dest_file,
		.acc_in, .jump_op, .jump_target, .call_op, .call_target, .config_load_op, .direction_load_op,
		.watchdog_refresh_op, .halt_op, .watchdog_timeout, .watchdog_base_tick, .timer_ext_input, .status_flags,
		.program_counter, .acc_result, .acc_result_valid, .timer_config, .pin_direction, .timer_tick, .watchdog_tick);
	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Every strobe is written once per cycle, so back to back operations never glitch.
	task automatic go(input logic [7:0] s, input cspc_pkg::cspc_op_t k = cspc_pkg::OP_PASS,
			input logic [4:0] a = 5'h00, input logic d = 1'h0, input logic [7:0] v = 8'h00, input logic [8:0] t = 9'h000);
		{op_valid, jump_op, call_op, config_load_op, direction_load_op, watchdog_refresh_op, halt_op, watchdog_timeout} = s;
		op_kind = k;
		op_addr = a;
		op_dest_file = d;
		acc_in = v;
		jump_target = t;
		call_target = t[7:0];
		@(posedge clk);
		#1;
		tt += int'(timer_tick);
		wt += int'(watchdog_tick);
	endtask
	task automatic idle(input int n);
		repeat (n) go(8'h00);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		go(S_OP, cspc_pkg::OP_PASS, a, 1'h1, v);
	endtask
	// A read adds zero to the file and returns the sum on the accumulator side.
	task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string what);
		int i;
		go(S_OP, cspc_pkg::OP_ADD, a, 1'h0, 8'h00);
		for (i = 0; i < 3 && acc_result_valid !== 1'h1; i++) go(8'h00);
		chk("acc valid", 16'h0001, {15'h0000, acc_result_valid});
		chk(what, exp, acc_result);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		chk("status", 8'h18, status_flags);
		chk("pc", 11'h7ff, program_counter);
		chk("config", 6'h3f, timer_config);
		chk("direction", 8'hff, pin_direction);
		$display("test reset done");
	endtask
	task automatic t_pc();
		go(8'h00);
		chk("pc wrap", 11'h000, program_counter);
		clk_en = 1'h0;
		idle(2);
		chk("pc frozen", 11'h000, program_counter);
		clk_en = 1'h1;
		wr(cspc_pkg::ADDR_STATUS, 8'h67);
		chk("status write", 8'h7f, status_flags);
		go(S_JMP, cspc_pkg::OP_PASS, 5'h00, 1'h0, 8'h00, 9'h1a5);
		chk("pc jump", 11'h7a5, program_counter);
		go(8'h00);
		chk("pc step", 11'h7a6, program_counter);
		go(S_CALL, cspc_pkg::OP_PASS, 5'h00, 1'h0, 8'h00, 9'h134);
		chk("pc call", 11'h634, program_counter);
		wr(cspc_pkg::ADDR_PC_LOW, 8'hc3);
		chk("pc low write", 11'h6c3, program_counter);
		wr(cspc_pkg::ADDR_STATUS, 8'h20);
		chk("status page", 8'h38, status_flags);
		go(S_JMP, cspc_pkg::OP_PASS, 5'h00, 1'h0, 8'h00, 9'h0ff);
		chk("pc page one", 11'h2ff, program_counter);
		$display("test pc done");
	endtask
	task automatic t_flags();
		wr(5'h08, 8'h0f);
		go(S_OP, cspc_pkg::OP_ADD, 5'h08, 1'h1, 8'h01);
		chk("add nibble", 3'h2, status_flags[2:0]);
		go(S_OP, cspc_pkg::OP_ADD, 5'h08, 1'h1, 8'hf0);
		chk("add carry", 3'h5, status_flags[2:0]);
		go(S_OP, cspc_pkg::OP_SUB, 5'h08, 1'h1, 8'h01);
		chk("sub borrow", 3'h0, status_flags[2:0]);
		go(S_OP, cspc_pkg::OP_SUB, 5'h08, 1'h1, 8'h0f);
		chk("sub clean", 3'h3, status_flags[2:0]);
		go(S_OP, cspc_pkg::OP_SUB, 5'h08, 1'h1, 8'hf0);
		chk("sub zero", 3'h7, status_flags[2:0]);
		wr(5'h08, 8'h01);
		go(S_OP, cspc_pkg::OP_ROT_L, 5'h08, 1'h0, 8'h00);
		chk("rotate left", 1'h0, status_flags[0]);
		go(S_OP, cspc_pkg::OP_ROT_R, 5'h08, 1'h0, 8'h00);
		chk("rotate right", 1'h1, status_flags[0]);
		wr(cspc_pkg::ADDR_STATUS, 8'h03);
		go(S_OP, cspc_pkg::OP_PASS_Z, cspc_pkg::ADDR_STATUS, 1'h1, 8'hff);
		chk("flag op on status", 8'hfb, status_flags);
		go(S_OP, cspc_pkg::OP_PASS_Z, cspc_pkg::ADDR_STATUS, 1'h1, 8'h00);
		chk("clear status", 8'h1f, status_flags);
		go(S_OP, cspc_pkg::OP_ADD, cspc_pkg::ADDR_STATUS, 1'h1, 8'h01);
		chk("add on status", 8'h3a, status_flags);
		$display("test flags done");
	endtask
	task automatic t_events();
		go(S_HALT);
		chk("halt", 2'h2, status_flags[4:3]);
		go(S_TO);
		chk("timeout", 2'h0, status_flags[4:3]);
		go(S_REF);
		chk("refresh", 2'h3, status_flags[4:3]);
		go(S_TO | S_REF);
		chk("timeout and refresh", 2'h1, status_flags[4:3]);
		go(S_HALT | S_REF);
		chk("halt and refresh", 2'h2, status_flags[4:3]);
		wr(cspc_pkg::ADDR_STATUS, 8'h00);
		chk("status protect", 8'h10, status_flags);
		$display("test events done");
	endtask
	task automatic t_config();
		int n;
		go(S_DIR, cspc_pkg::OP_PASS, 5'h00, 1'h0, 8'h5a);
		chk("direction", 8'h5a, pin_direction);
		go(S_CFG, cspc_pkg::OP_PASS, 5'h00, 1'h0, 8'hc5);
		wr(5'h1f, 8'h00);
		chk("config", 6'h05, timer_config);
		for (n = 0; n < 3; n++) begin
			go(S_CFG, cspc_pkg::OP_PASS, 5'h00, 1'h0, {5'h00, 3'(n)});
			tt = 0;
			idle((16 << n) + (1 << n));
			chk("timer ticks", 16'h0008, 16'(tt));
		end
		watchdog_base_tick = 1'h1;
		for (n = 1; n < 4; n++) begin
			go(S_CFG, cspc_pkg::OP_PASS, 5'h00, 1'h0, 8'h08 | 8'(n));
			wt = 0;
			idle((8 << n) + (1 << (n - 1)));
			chk("watchdog ticks", 16'h0008, 16'(wt));
		end
		watchdog_base_tick = 1'h0;
		$display("test config done");
	endtask
	// Two rising and one falling transition tell the edge choice apart at a divide of two.
	task automatic t_ext(input logic [5:0] cfg, input logic [15:0] exp);
		timer_ext_input = 1'h0;
		idle(6);
		go(S_CFG, cspc_pkg::OP_PASS, 5'h00, 1'h0, {2'h0, cfg});
		tt = 0;
		idle(10);
		chk("ext quiet", 16'h0000, 16'(tt));
		repeat (3) begin
			timer_ext_input = ~timer_ext_input;
			idle(4);
		end
		idle(8);
		chk("ext ticks", exp, 16'(tt));
		$display("test external done");
	endtask
	task automatic t_bank();
		wr(5'h10, 8'h22);
		wr(cspc_pkg::ADDR_POINTER, 8'h30);
		wr(cspc_pkg::ADDR_INDIRECT, 8'h11);
		wr(cspc_pkg::ADDR_POINTER, 8'h28);
		wr(cspc_pkg::ADDR_INDIRECT, 8'h77);
		rd(cspc_pkg::ADDR_INDIRECT, 8'h77, "indirect read");
		wr(cspc_pkg::ADDR_POINTER, 8'h30);
		rd(cspc_pkg::ADDR_INDIRECT, 8'h11, "upper bank");
		wr(cspc_pkg::ADDR_POINTER, 8'h10);
		rd(cspc_pkg::ADDR_INDIRECT, 8'h22, "bank zero upper");
		wr(cspc_pkg::ADDR_POINTER, 8'h00);
		rd(5'h08, 8'h77, "shared alias");
		rd(cspc_pkg::ADDR_INDIRECT, 8'h00, "window self");
		$display("test bank done");
	endtask
	// ---------------------------------------------------------------
	// Main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		#1;
		t_reset();
		rstn = 1'h1;
		t_pc();
		t_flags();
		t_events();
		t_config();
		t_ext(6'h20, 16'h0001);
		t_ext(6'h30, 16'h0000);
		t_bank();
		wrap_up();
	end
	initial begin
		#20000;
		n_mismatch++;
		$display("ERROR run expected done seen timeout");
		wrap_up();
	end
endmodule
